// ===== src/fan_pkg.sv
// constants for the two-channel fan speed control and tachometer block
// Contract
// - speed registers for both fans at 0x56, 0x57
// - bit 7 selects low or high clock
// - bits 6..1 duty code, high for code/64
// - code zero without override holds output low
// - code all ones gives 63 of 64 high
// - bit 0 forces output high, duty ignored
// - shared clock and divisor register at 0x58
// - two-bit count divisor per fan, bits 7..4
// - divisor two per fan after reset
// - multiplier bits 3, 2 double base clock
// - source select bits 1, 0 pick base
// - base rates 15.625k/23.438k or 40/60 Hz
// - both speed outputs low after reset
// - eight-bit count over one tach period
// - reference from slow pin or internal divider
// - count advances at reference over divisor
// - restart on tach rise or preload write
// - count saturates at 0xFF, never wraps
// - restart loads the programmed preload value
// - top two bits set raise enabled events
package fan_pkg;

    // ========================================
    // register indices (byte address = index * 4)
    localparam int unsigned IDX_PWM_CTRL_FIRST = 'h56;
    localparam int unsigned IDX_PWM_CTRL_SECOND = 'h57;
    localparam int unsigned IDX_PWM_CLOCK_DIVISOR_CTRL = 'h58;
    localparam int unsigned IDX_PRELOAD_FIRST = 'h59;
    localparam int unsigned IDX_PRELOAD_SECOND = 'h5A;
    localparam int unsigned IDX_COUNT_FIRST = 'h5B;
    localparam int unsigned IDX_COUNT_SECOND = 'h5C;
    localparam int unsigned IDX_EVENT_STATUS = 'h5D;
    localparam int unsigned IDX_WAKE_ENABLE_REG = 'h5E;
    localparam int unsigned IDX_MGMT_INT_ENABLE_REG = 'h5F;
    localparam int unsigned IDX_SLOW_CLOCK_CONFIG_REG = 'h60;
    localparam int unsigned ADDR_W = 12;

    // ========================================
    // field positions
    localparam int unsigned PWM_CLK_SEL_BIT = 7;
    localparam int unsigned PWM_DUTY_LSB = 1;
    localparam int unsigned PWM_FORCE_BIT = 0;
    localparam int unsigned DIV_FIELD_LSB_FIRST = 6;
    localparam int unsigned DIV_FIELD_LSB_SECOND = 4;
    localparam int unsigned MULT_BIT_FIRST = 3;
    localparam int unsigned MULT_BIT_SECOND = 2;
    localparam int unsigned SRC_BIT_FIRST = 1;
    localparam int unsigned SRC_BIT_SECOND = 0;
    localparam int unsigned EXT_PRESENT_BIT = 0;

    // ========================================
    // reset values
    localparam logic [7:0] PWM_CTRL_RST = 8'h00;
    localparam logic [7:0] DIVISOR_CTRL_RST = 8'h50;
    localparam logic [7:0] PRELOAD_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] SLOW_CLOCK_CFG_RST = 8'h00;

    // ========================================
    // timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned PWM_SLOTS = 64;
    localparam int unsigned PWM_FAST_LO_HZ = 15_625;
    localparam int unsigned PWM_FAST_HI_HZ = 23_438;
    localparam int unsigned PWM_SLOW_LO_HZ = 40;
    localparam int unsigned PWM_SLOW_HI_HZ = 60;
    localparam int unsigned SLOT_FAST_LO_CYC = CLK_HZ / (PWM_FAST_LO_HZ * PWM_SLOTS);
    localparam int unsigned SLOT_FAST_HI_CYC = CLK_HZ / (PWM_FAST_HI_HZ * PWM_SLOTS);
    localparam int unsigned SLOT_SLOW_LO_CYC = CLK_HZ / (PWM_SLOW_LO_HZ * PWM_SLOTS);
    localparam int unsigned SLOT_SLOW_HI_CYC = CLK_HZ / (PWM_SLOW_HI_HZ * PWM_SLOTS);
    localparam int unsigned SLOW_REF_HZ = 32_768;
    localparam int unsigned INT_REF_CYC = CLK_HZ / SLOW_REF_HZ;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [1:0] ALARM_BITS = 2'h3;

endpackage

// ===== src/fan_pwm_tach.sv
// two-channel fan speed outputs and tachometer counters behind APB
`timescale 1ns/1ps
module fan_pwm_tach #(
    parameter int unsigned SLOT_SLOW_LO = fan_pkg::SLOT_SLOW_LO_CYC,
    parameter int unsigned SLOT_SLOW_HI = fan_pkg::SLOT_SLOW_HI_CYC
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [fan_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // pins
    input wire logic EXT_SLOW_CLOCK_PIN,
    input wire logic TACH_IN_FIRST,
    input wire logic TACH_IN_SECOND,
    output logic PWM_OUT_FIRST,
    output logic PWM_OUT_SECOND,
    output logic WAKE_EVENT,
    output logic MGMT_INTERRUPT
);

    // ========================================
    // addresses
    localparam logic [fan_pkg::ADDR_W-1:0] A_PWM1 =
        fan_pkg::ADDR_W'(fan_pkg::IDX_PWM_CTRL_FIRST * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_PWM2 =
        fan_pkg::ADDR_W'(fan_pkg::IDX_PWM_CTRL_SECOND * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_DIV =
        fan_pkg::ADDR_W'(fan_pkg::IDX_PWM_CLOCK_DIVISOR_CTRL * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_PRE1 =
        fan_pkg::ADDR_W'(fan_pkg::IDX_PRELOAD_FIRST * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_PRE2 =
        fan_pkg::ADDR_W'(fan_pkg::IDX_PRELOAD_SECOND * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_CNT1 =
        fan_pkg::ADDR_W'(fan_pkg::IDX_COUNT_FIRST * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_CNT2 =
        fan_pkg::ADDR_W'(fan_pkg::IDX_COUNT_SECOND * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_STS =
        fan_pkg::ADDR_W'(fan_pkg::IDX_EVENT_STATUS * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_WEN =
        fan_pkg::ADDR_W'(fan_pkg::IDX_WAKE_ENABLE_REG * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_MEN =
        fan_pkg::ADDR_W'(fan_pkg::IDX_MGMT_INT_ENABLE_REG * 4);
    localparam logic [fan_pkg::ADDR_W-1:0] A_SCK =
        fan_pkg::ADDR_W'(fan_pkg::IDX_SLOW_CLOCK_CONFIG_REG * 4);
    localparam logic [15:0] SLOT_FL = 16'(fan_pkg::SLOT_FAST_LO_CYC);
    localparam logic [15:0] SLOT_FH = 16'(fan_pkg::SLOT_FAST_HI_CYC);
    localparam logic [15:0] SLOT_SL = 16'(SLOT_SLOW_LO);
    localparam logic [15:0] SLOT_SH = 16'(SLOT_SLOW_HI);
    localparam logic [11:0] INT_REF_LAST = 12'(fan_pkg::INT_REF_CYC - 1);

    // ========================================
    // registers
    logic [7:0] pwm_ctrl_r [2];
    logic [7:0] div_ctrl_r;
    logic [7:0] preload_r [2];
    logic [7:0] count_r [2];
    logic [7:0] last_count_r [2];
    logic [1:0] event_status_r;
    logic [7:0] wake_en_r;
    logic [7:0] mgmt_en_r;
    logic [7:0] slow_cfg_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [1:0] pwm_out_r;
    logic wake_r;
    logic mgmt_r;

    logic setup;
    logic wr_en;
    logic mapped;
    logic [7:0] wdata;
    logic [1:0] tach_pin;
    logic [1:0] preload_wr;
    logic [1:0] alarm;
    logic [1:0] sts_clear;
    logic sts_wr;
    logic [31:0] rdata_nxt;

    assign setup = PSEL & ~PENABLE;
    assign wr_en = PSEL & PENABLE & PWRITE & pready_r;
    assign wdata = PWDATA[7:0];
    assign tach_pin = {TACH_IN_SECOND, TACH_IN_FIRST};
    assign preload_wr[0] = wr_en & (PADDR == A_PRE1);
    assign preload_wr[1] = wr_en & (PADDR == A_PRE2);
    // status is write one to clear; count registers ignore writes
    assign sts_wr = wr_en & (PADDR == A_STS);
    assign sts_clear = sts_wr ? wdata[1:0] : 2'h0;

    // ========================================
    // apb read mux and decode
    always_comb begin
        mapped = 1'b1;
        rdata_nxt = 32'h0000_0000;
        case (PADDR)
            A_PWM1: rdata_nxt[7:0] = pwm_ctrl_r[0];
            A_PWM2: rdata_nxt[7:0] = pwm_ctrl_r[1];
            A_DIV: rdata_nxt[7:0] = div_ctrl_r;
            A_PRE1: rdata_nxt[7:0] = preload_r[0];
            A_PRE2: rdata_nxt[7:0] = preload_r[1];
            A_CNT1: rdata_nxt[7:0] = last_count_r[0];
            A_CNT2: rdata_nxt[7:0] = last_count_r[1];
            A_STS: rdata_nxt[1:0] = event_status_r;
            A_WEN: rdata_nxt[7:0] = wake_en_r;
            A_MEN: rdata_nxt[7:0] = mgmt_en_r;
            A_SCK: rdata_nxt[7:0] = slow_cfg_r;
            default: mapped = 1'b0;
        endcase
    end

    // answer one cycle after setup: access phase completes at once
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r <= (setup & ~PWRITE) ? rdata_nxt : 32'h0000_0000;
        end
    end

    // ========================================
    // software-written registers
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pwm_ctrl_r[0] <= fan_pkg::PWM_CTRL_RST;
            pwm_ctrl_r[1] <= fan_pkg::PWM_CTRL_RST;
            div_ctrl_r <= fan_pkg::DIVISOR_CTRL_RST;
            preload_r[0] <= fan_pkg::PRELOAD_RST;
            preload_r[1] <= fan_pkg::PRELOAD_RST;
            wake_en_r <= fan_pkg::ENABLE_RST;
            mgmt_en_r <= fan_pkg::ENABLE_RST;
            slow_cfg_r <= fan_pkg::SLOW_CLOCK_CFG_RST;
        end else if (wr_en) begin
            case (PADDR)
                A_PWM1: pwm_ctrl_r[0] <= wdata;
                A_PWM2: pwm_ctrl_r[1] <= wdata;
                A_DIV: div_ctrl_r <= wdata;
                A_PRE1: preload_r[0] <= wdata;
                A_PRE2: preload_r[1] <= wdata;
                A_WEN: wake_en_r <= {6'h00, wdata[1:0]};
                A_MEN: mgmt_en_r <= {6'h00, wdata[1:0]};
                A_SCK: slow_cfg_r <= {7'h00, wdata[0]};
                default: ;
            endcase
        end
    end

    // ========================================
    // slow reference: synchronised pin or internal divider
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic [11:0] int_div_r;
    logic ref_tick;
    logic [2:0] ref_div_r;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= EXT_SLOW_CLOCK_PIN;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            int_div_r <= 12'h000;
        end else if (int_div_r == INT_REF_LAST) begin
            int_div_r <= 12'h000;
        end else begin
            int_div_r <= int_div_r + 12'h001;
        end
    end

    always_comb begin
        if (slow_cfg_r[fan_pkg::EXT_PRESENT_BIT]) begin
            ref_tick = ext_s2_r & ~ext_s3_r;
        end else begin
            ref_tick = (int_div_r == INT_REF_LAST);
        end
    end

    // shared prescaler for divide by 1, 2, 4, 8
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ref_div_r <= 3'h0;
        end else if (ref_tick) begin
            ref_div_r <= ref_div_r + 3'h1;
        end
    end

    // ========================================
    // per-channel pwm and tachometer
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            localparam int unsigned DLSB = (ch == 0) ?
                fan_pkg::DIV_FIELD_LSB_FIRST : fan_pkg::DIV_FIELD_LSB_SECOND;
            localparam int unsigned MBIT = (ch == 0) ?
                fan_pkg::MULT_BIT_FIRST : fan_pkg::MULT_BIT_SECOND;
            localparam int unsigned SBIT = (ch == 0) ?
                fan_pkg::SRC_BIT_FIRST : fan_pkg::SRC_BIT_SECOND;

            logic [15:0] slot_len;
            logic [15:0] slot_cnt_r;
            logic [5:0] slot_idx_r;
            logic [5:0] duty_code;
            logic [1:0] div_code;
            logic cnt_tick;
            logic t1_r;
            logic t2_r;
            logic t3_r;
            logic tach_rise;

            // base slot length from source, clock select, multiplier
            always_comb begin
                case ({div_ctrl_r[SBIT],
                       pwm_ctrl_r[ch][fan_pkg::PWM_CLK_SEL_BIT]})
                    2'b00: slot_len = SLOT_FL;
                    2'b01: slot_len = SLOT_FH;
                    2'b10: slot_len = SLOT_SL;
                    default: slot_len = SLOT_SH;
                endcase
                if (div_ctrl_r[MBIT]) begin
                    slot_len = slot_len >> 1;
                end
            end

            assign duty_code = pwm_ctrl_r[ch][fan_pkg::PWM_DUTY_LSB +: 6];

            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    slot_cnt_r <= 16'h0000;
                    slot_idx_r <= 6'h00;
                end else if (slot_cnt_r >= slot_len - 16'h0001) begin
                    slot_cnt_r <= 16'h0000;
                    slot_idx_r <= slot_idx_r + 6'h01;
                end else begin
                    slot_cnt_r <= slot_cnt_r + 16'h0001;
                end
            end

            // high while slot index below the code: 0 never, 63 of 64 max
            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    pwm_out_r[ch] <= 1'b0;
                end else if (pwm_ctrl_r[ch][fan_pkg::PWM_FORCE_BIT]) begin
                    pwm_out_r[ch] <= 1'b1;
                end else begin
                    pwm_out_r[ch] <= (slot_idx_r < duty_code);
                end
            end

            // tach pin synchroniser and rising edge
            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    t1_r <= 1'b0;
                    t2_r <= 1'b0;
                    t3_r <= 1'b0;
                end else begin
                    t1_r <= tach_pin[ch];
                    t2_r <= t1_r;
                    t3_r <= t2_r;
                end
            end
            assign tach_rise = t2_r & ~t3_r;

            assign div_code = div_ctrl_r[DLSB +: 2];
            always_comb begin
                case (div_code)
                    2'b00: cnt_tick = ref_tick;
                    2'b01: cnt_tick = ref_tick & ref_div_r[0];
                    2'b10: cnt_tick = ref_tick & (&ref_div_r[1:0]);
                    default: cnt_tick = ref_tick & (&ref_div_r);
                endcase
            end

            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    count_r[ch] <= fan_pkg::PRELOAD_RST;
                    last_count_r[ch] <= 8'h00;
                end else if (tach_rise) begin
                    last_count_r[ch] <= count_r[ch];
                    count_r[ch] <= preload_r[ch];
                end else if (preload_wr[ch]) begin
                    count_r[ch] <= wdata;
                end else if (cnt_tick && count_r[ch] != fan_pkg::COUNT_MAX) begin
                    count_r[ch] <= count_r[ch] + 8'h01;
                end
            end

            assign alarm[ch] = (count_r[ch][7:6] == fan_pkg::ALARM_BITS);
        end
    endgenerate

    // ========================================
    // sticky alarm status, write one to clear, set wins
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            event_status_r <= 2'h0;
        end else begin
            event_status_r <= (event_status_r & ~sts_clear) | alarm;
        end
    end

    // wake event, masked per channel
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= |(event_status_r & wake_en_r[1:0]);
        end
    end

    // management interrupt, masked per channel
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            mgmt_r <= 1'b0;
        end else begin
            mgmt_r <= |(event_status_r & mgmt_en_r[1:0]);
        end
    end

    // ========================================
    // outputs
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PWM_OUT_FIRST = pwm_out_r[0];
    assign PWM_OUT_SECOND = pwm_out_r[1];
    assign WAKE_EVENT = wake_r;
    assign MGMT_INTERRUPT = mgmt_r;

endmodule // fan_pwm_tach

// ===== tb/fan_pwm_tach_chk.sv
// port-level assertions for the fan speed and tachometer block
`timescale 1ns/1ps
module fan_pwm_tach_chk (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [fan_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // pins
    input wire logic EXT_SLOW_CLOCK_PIN,
    input wire logic TACH_IN_FIRST,
    input wire logic TACH_IN_SECOND,
    input wire logic PWM_OUT_FIRST,
    input wire logic PWM_OUT_SECOND,
    input wire logic WAKE_EVENT,
    input wire logic MGMT_INTERRUPT
);
    // ========================================
    // helpers
    localparam int unsigned AW = fan_pkg::ADDR_W;
    logic mapped;
    logic wr_pwm;
    logic wr_wake;
    assign mapped = PADDR[1:0] == 2'h0
        && PADDR >= AW'(fan_pkg::IDX_PWM_CTRL_FIRST * 4)
        && PADDR <= AW'(fan_pkg::IDX_SLOW_CLOCK_CONFIG_REG * 4);
    assign wr_pwm = PSEL && PENABLE && PREADY && PWRITE
        && PADDR == AW'(fan_pkg::IDX_PWM_CTRL_FIRST * 4);
    assign wr_wake = PSEL && PENABLE && PREADY && PWRITE
        && PADDR == AW'(fan_pkg::IDX_WAKE_ENABLE_REG * 4);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    // ========================================
    // properties
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_access; PSEL && PENABLE && PREADY; endsequence
    property p_ready_next; s_setup |=> s_access; endproperty
    a_ready_next: assert property (p_ready_next)
        else $error("ready missing after setup");
    property p_ready_single; PREADY |=> !PREADY; endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("ready held too long");
    property p_rdata_idle; !PREADY |-> PRDATA == 32'h00000000; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside access");
    property p_rdata_byte; PREADY |-> PRDATA[31:8] == 24'h000000; endproperty
    a_rdata_byte: assert property (p_rdata_byte)
        else $error("read data upper bits set");
    property p_unmapped;
        s_setup ##0 !mapped |=> PSLVERR && PRDATA == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_reset_low;
        $fell(RST) |-> (!PWM_OUT_FIRST && !PWM_OUT_SECOND) [*2];
    endproperty
    a_reset_low: assert property (p_reset_low)
        else $error("speed output high after reset");
    property p_force_high; wr_pwm && PWDATA[0] |-> ##[1:3] PWM_OUT_FIRST;
    endproperty
    a_force_high: assert property (p_force_high)
        else $error("override did not force output high");
    property p_zero_low;
        wr_pwm && PWDATA[7:0] == 8'h00 |-> ##3 (!PWM_OUT_FIRST) [*8];
    endproperty
    a_zero_low: assert property (p_zero_low)
        else $error("zero duty output not low");
    property p_wake_off;
        wr_wake && PWDATA[1:0] == 2'h0 |-> ##2 (!WAKE_EVENT) [*2];
    endproperty
    a_wake_off: assert property (p_wake_off)
        else $error("wake event stays with enable cleared");
endmodule // fan_pwm_tach_chk
bind fan_pwm_tach fan_pwm_tach_chk u_chk (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXT_SLOW_CLOCK_PIN(EXT_SLOW_CLOCK_PIN), .TACH_IN_FIRST(TACH_IN_FIRST),
    .TACH_IN_SECOND(TACH_IN_SECOND), .PWM_OUT_FIRST(PWM_OUT_FIRST),
    .PWM_OUT_SECOND(PWM_OUT_SECOND), .WAKE_EVENT(WAKE_EVENT),
    .MGMT_INTERRUPT(MGMT_INTERRUPT));

// ===== tb/fan_model.sv
// behavioural fan: tachometer pulses of a set period
`timescale 1ns/1ps
module fan_model (
    // control from the bench
    input wire logic run,
    input wire logic [31:0] period_ns,
    // tachometer pin
    output logic tach
);
    // offset keeps pulse edges away from clock edges
    initial begin
        tach = 1'b0;
        #3;
        forever begin
            if (run) begin
                tach = 1'b1;
                #(period_ns / 2);
                tach = 1'b0;
                #(period_ns - period_ns / 2);
            end else begin
                #10;
            end
        end
    end
endmodule // fan_model

// ===== tb/fan_pwm_tach_tb.sv
// self-checking bench for the fan speed and tachometer block
`timescale 1ns/1ps
module fan_pwm_tach_tb;
    // ========================================
    // settings and signals
    localparam int unsigned AW = fan_pkg::ADDR_W;
    localparam int SLOW_LO = 8;
    localparam int SLOW_HI = 6;
    localparam int T_CH [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
    localparam logic [7:0] T_CTRL [9] = '{8'h00, 8'h7E, 8'h2A, 8'h2B,
        8'hC0, 8'h40, 8'h20, 8'h40, 8'hC0};
    localparam logic [7:0] T_DIV [9] = '{8'h52, 8'h52, 8'h52, 8'h52,
        8'h52, 8'h5A, 8'h50, 8'h51, 8'h55};
    localparam int T_SLOT [9] = '{SLOW_LO, SLOW_LO, SLOW_LO, SLOW_LO,
        SLOW_HI, SLOW_LO / 2, fan_pkg::SLOT_FAST_LO_CYC, SLOW_LO, SLOW_HI / 2};
    logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, rerr;
    logic [AW-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rdata, per_first, per_second;
    logic EXT_SLOW_CLOCK_PIN, TACH_IN_FIRST, TACH_IN_SECOND;
    logic PWM_OUT_FIRST, PWM_OUT_SECOND, WAKE_EVENT, MGMT_INTERRUPT;
    logic run_first, run_second;
    int failures, total_checks, per, exp_hi, hi;
    fan_pwm_tach #(.SLOT_SLOW_LO(SLOW_LO), .SLOT_SLOW_HI(SLOW_HI)) DUT (
        .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR),
        .EXT_SLOW_CLOCK_PIN(EXT_SLOW_CLOCK_PIN),
        .TACH_IN_FIRST(TACH_IN_FIRST), .TACH_IN_SECOND(TACH_IN_SECOND),
        .PWM_OUT_FIRST(PWM_OUT_FIRST), .PWM_OUT_SECOND(PWM_OUT_SECOND),
        .WAKE_EVENT(WAKE_EVENT), .MGMT_INTERRUPT(MGMT_INTERRUPT));
    fan_model u_fan_first (.run(run_first), .period_ns(per_first),
        .tach(TACH_IN_FIRST));
    fan_model u_fan_second (.run(run_second), .period_ns(per_second),
        .tach(TACH_IN_SECOND));
    // external slow reference, 160 ns period to keep runs short
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    initial begin
        EXT_SLOW_CLOCK_PIN = 1'b0;
        forever #80 EXT_SLOW_CLOCK_PIN = ~EXT_SLOW_CLOCK_PIN;
    end
    // ========================================
    // tasks
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input int unsigned idx,
            input logic [7:0] wd);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= AW'(idx * 4);
        PWDATA <= {24'h000000, wd};
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            check("apb_ready", {31'h0, PREADY}, 32'h1);
            end_of_test();
        end else begin
            rdata = PRDATA;
            rerr = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
            @(posedge CLOCK);
        end
    endtask
    task automatic wr(input int unsigned idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask
    task automatic rd(input int unsigned idx);
        apb(1'b0, idx, 8'h00);
    endtask
    // ========================================
    // main sequence
    initial begin
        RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = '0;
        PWDATA = 32'h0;
        run_first = 1'b0;
        run_second = 1'b0;
        per_first = 32'h000003E8;
        per_second = 32'h00013880;
        failures = 0;
        total_checks = 0;
        repeat (8) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        rd(fan_pkg::IDX_PWM_CTRL_FIRST);
        check("pwm_ctrl_first_rst", rdata, 32'h0);
        rd(fan_pkg::IDX_PWM_CTRL_SECOND);
        check("pwm_ctrl_second_rst", rdata, 32'h0);
        rd(fan_pkg::IDX_PWM_CLOCK_DIVISOR_CTRL);
        check("divisor_ctrl_rst", rdata, 32'h50);
        check("pwm_outs_rst", {30'h0, PWM_OUT_SECOND, PWM_OUT_FIRST}, 32'h0);
        rd('h61);
        check("unmapped_err", {31'h0, rerr}, 32'h1);
        check("unmapped_data", rdata, 32'h0);
        for (int i = 0; i < 9; i++) begin
            wr(fan_pkg::IDX_PWM_CTRL_FIRST + T_CH[i], T_CTRL[i]);
            wr(fan_pkg::IDX_PWM_CLOCK_DIVISOR_CTRL, T_DIV[i]);
            rd(fan_pkg::IDX_PWM_CTRL_FIRST + T_CH[i]);
            check("pwm_ctrl_readback", rdata, {24'h0, T_CTRL[i]});
            rd(fan_pkg::IDX_PWM_CLOCK_DIVISOR_CTRL);
            check("divisor_readback", rdata, {24'h0, T_DIV[i]});
            per = fan_pkg::PWM_SLOTS * T_SLOT[i];
            exp_hi = T_CTRL[i][0] ? per : int'(T_CTRL[i][6:1]) * T_SLOT[i];
            repeat (per) @(posedge CLOCK);
            hi = 0;
            for (int k = 0; k < per; k++) begin
                @(posedge CLOCK);
                if ((T_CH[i] ? PWM_OUT_SECOND : PWM_OUT_FIRST) === 1'b1) hi++;
            end
            check("pwm_high_cycles", 32'(hi), 32'(exp_hi));
        end
        wr(fan_pkg::IDX_SLOW_CLOCK_CONFIG_REG, 8'h01);
        wr(fan_pkg::IDX_PRELOAD_FIRST, 8'h20);
        wr(fan_pkg::IDX_PRELOAD_SECOND, 8'h20);
        run_first <= 1'b1;
        run_second <= 1'b1;
        // each first-fan period spans 32 divided reference ticks
        for (int c = 0; c < 4; c++) begin
            per_first <= 32'(5120 * (1 << c));
            wr(fan_pkg::IDX_PWM_CLOCK_DIVISOR_CTRL,
                8'(c << fan_pkg::DIV_FIELD_LSB_FIRST));
            repeat (1536 * (1 << c)) @(posedge CLOCK);
            rd(fan_pkg::IDX_COUNT_FIRST);
            check("count_first", {31'h0, rdata[7:0] >= 8'h3F
                && rdata[7:0] <= 8'h41}, 32'h1);
        end
        rd(fan_pkg::IDX_COUNT_SECOND);
        check("count_second_sat", rdata, 32'hFF);
        run_second <= 1'b0;
        repeat (4000) @(posedge CLOCK);
        wr(fan_pkg::IDX_EVENT_STATUS, 8'h03);
        rd(fan_pkg::IDX_EVENT_STATUS);
        check("status_alarm", rdata, 32'h2);
        wr(fan_pkg::IDX_WAKE_ENABLE_REG, 8'h02);
        wr(fan_pkg::IDX_MGMT_INT_ENABLE_REG, 8'h01);
        repeat (3) @(posedge CLOCK);
        check("wake_event", {31'h0, WAKE_EVENT}, 32'h1);
        check("mgmt_masked", {31'h0, MGMT_INTERRUPT}, 32'h0);
        wr(fan_pkg::IDX_MGMT_INT_ENABLE_REG, 8'h02);
        repeat (3) @(posedge CLOCK);
        check("mgmt_event", {31'h0, MGMT_INTERRUPT}, 32'h1);
        wr(fan_pkg::IDX_WAKE_ENABLE_REG, 8'h00);
        wr(fan_pkg::IDX_PRELOAD_SECOND, 8'h40);
        wr(fan_pkg::IDX_EVENT_STATUS, 8'h03);
        rd(fan_pkg::IDX_EVENT_STATUS);
        check("status_restart", rdata, 32'h0);
        // 128 ticks of 16 cycles bring 0x40 up to 192
        repeat (1850) @(posedge CLOCK);
        check("mgmt_below", {31'h0, MGMT_INTERRUPT}, 32'h0);
        repeat (450) @(posedge CLOCK);
        check("mgmt_at_limit", {31'h0, MGMT_INTERRUPT}, 32'h1);
        end_of_test();
    end
endmodule // fan_pwm_tach_tb
